// [core/imt_meter_table.sv]
// Purpose: Register port and indirect access to the metering table.
// Assumes: Register port and engine lookup run on ref_clk.
// Notes:   A command takes one cycle; pending is high for exactly that cycle.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Each command write starts one table access
// - Bit 7 one reads, zero writes
// - Bits 6:5 select rate, committed, excess
// - Bits 4:0 index one of 24 rates
// - Port-and-priority: eight entries each for ports 0 to 2; port 3 sees a zero rate
// - Port-only: entries 0, 1, 2, 3, one per port
// - Priority-only: entry index equals priority
// - Table: 24 rates, two bursts, 16 bits
// - Excess burst limit resets to 0600h
// - Committed burst limit resets to 0600h
// - Token buckets start at 0600h
// - Rate time per byte (value+1)*20ns
// - Pending set during command, clears itself
// - Data holding registers 16 bits, reset zero
// - Mode encoding: 00, 01, 10 defined
module imt_meter_table (
   input  wire logic                          ref_clk,
   input  wire logic                          rst_b,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   input  wire logic [imt_pkg::ADDR_W-1:0]    reg_addr,
   input  wire logic [31:0]                   reg_wdata,
   output logic      [31:0]                   reg_rdata,
   output logic                               reg_err,
   input  wire logic [1:0]                    meter_port,
   input  wire logic [4:0]                    meter_prio,
   output logic      [imt_pkg::ENTRY_W-1:0]   meter_rate,
   output logic                               meter_enable,
   output logic      [1:0]                    meter_mode,
   output logic      [imt_pkg::ENTRY_W-1:0]   committed_burst_limit,
   output logic      [imt_pkg::ENTRY_W-1:0]   excess_burst_limit,
   output logic      [imt_pkg::ENTRY_W-1:0]   bucket_init
);
   import imt_pkg::*;

   typedef enum logic {IMT_IDLE, IMT_ACCESS} imt_state_t;

   imt_state_t          state;
   logic [7:0]          meter_table_command;
   logic [2:0]          meter_config;
   logic [ENTRY_W-1:0]  meter_table_write_data;
   logic [ENTRY_W-1:0]  meter_table_read_data;
   logic                access_direction;
   logic [1:0]          table_select;
   logic [4:0]          rate_entry_index;
   logic                pending;
   logic                cmd_hit;
   logic [SLOT_W-1:0]   access_slot;
   logic                slot_ok;
   logic                store_wr;
   logic [ENTRY_W-1:0]  store_rd;
   logic [SLOT_W-1:0]   lookup_slot;
   logic [ENTRY_W-1:0]  lookup_data;

   // ************************************************************
   // Command decode
   // ************************************************************
   assign cmd_hit          = reg_wr && reg_addr == REG_COMMAND;
   assign access_direction = meter_table_command[CMD_DIR_BIT];
   assign table_select     = meter_table_command[CMD_SEL_HI:CMD_SEL_LO];
   assign rate_entry_index = meter_table_command[CMD_IDX_HI:CMD_IDX_LO];
   assign pending          = state == IMT_ACCESS;

   // The reserved selector and an index past the rates touch no entry, and a read of one loads zero;
   // such a command still runs its cycle so that pending behaves alike.
   always_comb begin
      access_slot = rate_entry_index;
      slot_ok     = 1'b0;
      unique case (table_select)
         SEL_RATE: slot_ok = rate_entry_index < SLOT_W'(NUM_RATE);
         SEL_CBS: begin
            access_slot = SLOT_CBS;
            slot_ok     = 1'b1;
         end
         SEL_EBS: begin
            access_slot = SLOT_EBS;
            slot_ok     = 1'b1;
         end
         SEL_RSVD: slot_ok = 1'b0;
      endcase
   end

   assign store_wr = pending && slot_ok && !access_direction;

   // ************************************************************
   // Registers written by software
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         meter_table_command <= CMD_RESET;
      end else if (cmd_hit) begin
         meter_table_command <= reg_wdata[7:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         meter_config <= CFG_RESET;
      end else if (reg_wr && reg_addr == REG_CONFIG) begin
         meter_config <= reg_wdata[2:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         meter_table_write_data <= DATA_RESET;
      end else if (reg_wr && reg_addr == REG_WRITE_DATA) begin
         meter_table_write_data <= reg_wdata[ENTRY_W-1:0];
      end
   end

   // ************************************************************
   // Access sequencer
   // ************************************************************
   // A new command write while one is pending lets that access finish, then runs
   // a second one with the new fields; software is expected to wait for pending to drop.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= IMT_IDLE;
      end else if (cmd_hit) begin
         state <= IMT_ACCESS;
      end else begin
         state <= IMT_IDLE;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         meter_table_read_data <= DATA_RESET;
      end else if (pending && access_direction) begin
         meter_table_read_data <= slot_ok ? store_rd : DATA_RESET;
      end
   end

   // ************************************************************
   // Software read path
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 32'h0000_0000;
         reg_err   <= 1'b0;
      end else begin
         reg_err <= 1'b0;
         if (reg_rd) begin
            reg_rdata <= 32'h0000_0000;
            unique case (reg_addr)
               REG_CONFIG:     reg_rdata[2:0] <= meter_config;
               REG_COMMAND:    reg_rdata[7:0] <= meter_table_command;
               REG_STATUS:     reg_rdata[STS_PEND_BIT] <= pending;
               REG_WRITE_DATA:
                  reg_rdata[ENTRY_W-1:0] <= meter_table_write_data;
               REG_READ_DATA:
                  reg_rdata[ENTRY_W-1:0] <= meter_table_read_data;
               default:        reg_err <= 1'b1;
            endcase
         end
      end
   end

   // ************************************************************
   // Engine lookup
   // ************************************************************
   assign meter_enable = meter_config[CFG_EN_BIT];
   assign meter_mode   = meter_config[CFG_MODE_HI:CFG_MODE_LO];

   // The reserved mode maps to no entry, so the engine sees a zero rate.
   always_comb begin
      lookup_slot = SLOT_W'(NUM_SLOT);
      unique case (meter_mode)
         MODE_PORT_PRIO:
            lookup_slot = {meter_port, meter_prio[2:0]} +
                          SLOT_W'(0);
         MODE_PORT_ONLY:
            lookup_slot = {3'h0, meter_port};
         MODE_PRIO_ONLY:
            lookup_slot = meter_prio;
         default:
            lookup_slot = SLOT_W'(NUM_SLOT);
      endcase
   end

   // Registered so the engine sees a stable rate, one cycle after lookup.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         meter_rate <= RATE_RESET;
      end else begin
         meter_rate <= lookup_data;
      end
   end

   assign bucket_init = BUCKET_INIT;

   imt_entry_store u_store (
      .ref_clk  (ref_clk),
      .rst_b    (rst_b),
      .wr_en    (store_wr),
      .wr_slot  (access_slot),
      .wr_data  (meter_table_write_data),
      .rd_slot  (access_slot),
      .rd_data  (store_rd),
      .lk_slot  (lookup_slot),
      .lk_data  (lookup_data),
      .cbs_data (committed_burst_limit),
      .ebs_data (excess_burst_limit)
   );
endmodule : imt_meter_table
`default_nettype wire

// [inc/imt_pkg.sv]
// Purpose: Shared constants for the ingress meter table access block.
// Assumes: Register addresses are register numbers, one 32-bit word each.
// Notes:   Entry slots 0..23 are rates, then committed and excess burst.
package imt_pkg;
   // ************************************************************
   // Register map
   // ************************************************************
   localparam int          ADDR_W         = 16;
   localparam logic [15:0] REG_CONFIG     = 16'h184A;
   localparam logic [15:0] REG_COMMAND    = 16'h184B;
   localparam logic [15:0] REG_STATUS     = 16'h184C;
   localparam logic [15:0] REG_WRITE_DATA = 16'h184D;
   localparam logic [15:0] REG_READ_DATA  = 16'h184E;

   // ************************************************************
   // Field layout
   // ************************************************************
   localparam int CMD_DIR_BIT  = 7;
   localparam int CMD_SEL_HI   = 6;
   localparam int CMD_SEL_LO   = 5;
   localparam int CMD_IDX_HI   = 4;
   localparam int CMD_IDX_LO   = 0;
   localparam int STS_PEND_BIT = 0;
   localparam int CFG_EN_BIT   = 0;
   localparam int CFG_MODE_HI  = 2;
   localparam int CFG_MODE_LO  = 1;

   localparam logic [1:0] SEL_RSVD = 2'h0;
   localparam logic [1:0] SEL_RATE = 2'h1;
   localparam logic [1:0] SEL_CBS  = 2'h2;
   localparam logic [1:0] SEL_EBS  = 2'h3;

   localparam logic [1:0] MODE_PORT_PRIO = 2'h0;
   localparam logic [1:0] MODE_PORT_ONLY = 2'h1;
   localparam logic [1:0] MODE_PRIO_ONLY = 2'h2;

   // ************************************************************
   // Table shape and reset values
   // ************************************************************
   localparam int          ENTRY_W     = 16;
   localparam int          SLOT_W      = 5;
   localparam int          NUM_RATE    = 24;
   localparam int          NUM_SLOT    = 26;
   localparam logic [4:0]  SLOT_CBS    = 5'h18;
   localparam logic [4:0]  SLOT_EBS    = 5'h19;
   localparam int          GROUP_SHIFT = 3;
   localparam logic [15:0] RATE_RESET  = 16'h0014;
   localparam logic [15:0] BURST_RESET = 16'h0600;
   localparam logic [15:0] BUCKET_INIT = 16'h0600;
   localparam logic [15:0] DATA_RESET  = 16'h0000;
   localparam logic [7:0]  CMD_RESET   = 8'h00;
   localparam logic [2:0]  CFG_RESET   = 3'h0;
   localparam int          STEP_NS     = 20;
endpackage : imt_pkg

// [core/imt_entry_store.sv]
// Purpose: Flip-flop storage for the 24 rate entries and two burst limits.
// Assumes: One write port, one software read port, one engine lookup port.
// Notes:   Slots at or above NUM_SLOT read as zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module imt_entry_store (
   input  wire logic                          ref_clk,
   input  wire logic                          rst_b,
   input  wire logic                          wr_en,
   input  wire logic [imt_pkg::SLOT_W-1:0]    wr_slot,
   input  wire logic [imt_pkg::ENTRY_W-1:0]   wr_data,
   input  wire logic [imt_pkg::SLOT_W-1:0]    rd_slot,
   output logic      [imt_pkg::ENTRY_W-1:0]   rd_data,
   input  wire logic [imt_pkg::SLOT_W-1:0]    lk_slot,
   output logic      [imt_pkg::ENTRY_W-1:0]   lk_data,
   output logic      [imt_pkg::ENTRY_W-1:0]   cbs_data,
   output logic      [imt_pkg::ENTRY_W-1:0]   ebs_data
);
   import imt_pkg::*;

   logic [ENTRY_W-1:0] slot_q [NUM_SLOT];

   // ************************************************************
   // Entries
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < NUM_SLOT; g++) begin : g_slot
         localparam logic [ENTRY_W-1:0] INIT =
            (g < NUM_RATE) ? RATE_RESET : BURST_RESET;
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               slot_q[g] <= INIT;
            end else if (wr_en && wr_slot == SLOT_W'(g)) begin
               slot_q[g] <= wr_data;
            end
         end
      end
   endgenerate

   always_comb begin
      rd_data = DATA_RESET;
      lk_data = DATA_RESET;
      if (rd_slot < SLOT_W'(NUM_SLOT)) begin
         rd_data = slot_q[rd_slot];
      end
      if (lk_slot < SLOT_W'(NUM_RATE)) begin
         lk_data = slot_q[lk_slot];
      end
   end

   assign cbs_data = slot_q[SLOT_CBS];
   assign ebs_data = slot_q[SLOT_EBS];
endmodule : imt_entry_store
`default_nettype wire

// [sim/imt_meter_table_asserts.sv]
// Purpose: Concurrent checks on the meter table register port.
// Assumes: Bound to imt_meter_table; one clock domain.
// Notes:   Pending is only visible through status reads.
`timescale 1ns/1ps
`default_nettype none
module imt_meter_table_asserts (
   input wire logic                        ref_clk,
   input wire logic                        rst_b,
   input wire logic                        reg_wr,
   input wire logic                        reg_rd,
   input wire logic [imt_pkg::ADDR_W-1:0]  reg_addr,
   input wire logic [31:0]                 reg_wdata,
   input wire logic [31:0]                 reg_rdata,
   input wire logic                        reg_err,
   input wire logic                        meter_enable,
   input wire logic [1:0]                  meter_mode,
   input wire logic [imt_pkg::ENTRY_W-1:0] committed_burst_limit,
   input wire logic [imt_pkg::ENTRY_W-1:0] bucket_init
);
   import imt_pkg::*;
   // ************************************************************
   // Properties
   // ************************************************************
   logic cw;
   logic mapped;
   assign cw     = reg_wr && reg_addr == REG_COMMAND;
   assign mapped = reg_addr >= REG_CONFIG && reg_addr <= REG_READ_DATA;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   property p_unmap; reg_rd && !mapped |=> reg_err && reg_rdata == 32'h0000_0000; endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped read not flagged");
   property p_noerr; !reg_rd |=> !reg_err; endproperty
   a_noerr: assert property (p_noerr)
      else $error("error pulse without a read");
   property p_pset; cw ##1 (reg_rd && reg_addr == REG_STATUS) |=> reg_rdata == 32'h0000_0001; endproperty
   a_pset: assert property (p_pset)
      else $error("pending not set after command");
   property p_pclr; !cw ##1 (reg_rd && reg_addr == REG_STATUS) |=> reg_rdata == 32'h0000_0000; endproperty
   a_pclr: assert property (p_pclr)
      else $error("pending did not clear");
   property p_upper; reg_rd |=> reg_rdata[31:16] == 16'h0000; endproperty
   a_upper: assert property (p_upper)
      else $error("upper read bits not zero");
   property p_wdata; (reg_wr && reg_addr == REG_WRITE_DATA) ##1 (reg_rd && !reg_wr && reg_addr == REG_WRITE_DATA)
      |=> reg_rdata == (32'h0000_FFFF & $past(reg_wdata, 2)); endproperty
   a_wdata: assert property (p_wdata)
      else $error("write data readback wrong");
   property p_cfg; reg_wr && reg_addr == REG_CONFIG |=> {meter_mode, meter_enable} == 3'($past(reg_wdata)); endproperty
   a_cfg: assert property (p_cfg)
      else $error("config outputs do not follow write");
   property p_burst; !$stable(committed_burst_limit) |-> $past(cw, 2); endproperty
   a_burst: assert property (p_burst)
      else $error("burst limit changed without a command");
   property p_bucket; bucket_init == BUCKET_INIT; endproperty
   a_bucket: assert property (p_bucket)
      else $error("bucket start value wrong");
   c_unmap: cover property (reg_rd && !mapped);
   c_pend: cover property (cw ##1 (reg_rd && reg_addr == REG_STATUS));
   c_cfg: cover property (reg_wr && reg_addr == REG_CONFIG);
endmodule : imt_meter_table_asserts
bind imt_meter_table imt_meter_table_asserts imt_meter_table_asserts_i (.ref_clk, .rst_b,
   .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_err, .meter_enable,
   .meter_mode, .committed_burst_limit, .bucket_init);
`default_nettype wire

// [sim/imt_meter_table_test.sv]
// Purpose: Self-checking bench for the meter table access block.
// Assumes: Reads are answered one cycle after the strobe.
// Notes:   Expected read results wait in a queue for the monitor.
`timescale 1ns/1ps
`default_nettype none
module imt_meter_table_test;
   import imt_pkg::*;
   // ************************************************************
   // Stimulus, model and monitor
   // ************************************************************
   logic        ref_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
   logic [15:0] reg_addr = 16'h0000, meter_rate, cbl, ebl, bkt, tab [NUM_SLOT];
   logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
   logic [1:0]  meter_port = 2'h0, meter_mode;
   logic [4:0]  meter_prio = 5'h00;
   logic        reg_err, meter_enable;
   logic [32:0] expq [$];
   int          errors = 0, n_checks = 0, cyc = 0;
   imt_meter_table imt_meter_table_i (.ref_clk, .rst_b, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata, .reg_err, .meter_port, .meter_prio, .meter_rate,
      .meter_enable, .meter_mode, .committed_burst_limit(cbl), .excess_burst_limit(ebl),
      .bucket_init(bkt));
   always #20 ref_clk = ~ref_clk;
   task automatic test_done;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Compared at the falling edge so the registered answer has settled.
   always @(posedge ref_clk) rd_d <= reg_rd;
   always @(negedge ref_clk) if (rd_d) chk({reg_err, reg_rdata}, expq.size() ? expq.pop_front() : 33'h1_dead_beef);
   always @(posedge ref_clk) if (++cyc == 3000) begin
      errors++;
      test_done();
   end
   task automatic drv(input logic w, r, input logic [15:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
   endtask : drv
   task automatic rd(input logic [15:0] a, input logic [32:0] x);
      expq.push_back(x);
      drv(1'b0, 1'b1, a, 32'h0000_0000);
   endtask : rd
   function automatic int slot(input logic [1:0] s, input logic [4:0] i);
      if (s == SEL_RATE) return i < NUM_RATE ? int'(i) : -1;
      return s == SEL_CBS ? int'(SLOT_CBS) : s == SEL_EBS ? int'(SLOT_EBS) : -1;
   endfunction : slot
   // A write leaves the data register loaded first, then issues the command.
   task automatic tacc(input logic rw, input logic [1:0] s, input logic [4:0] i, input logic [15:0] d);
      if (!rw) drv(1'b1, 1'b0, REG_WRITE_DATA, {16'h0000, d});
      drv(1'b1, 1'b0, REG_COMMAND, {24'h00_0000, rw, s, i});
      rd(REG_STATUS, 33'h0_0000_0001);
      rd(REG_STATUS, 33'h0_0000_0000);
      if (rw) rd(REG_READ_DATA, {17'h0_0000, d});
      drv(1'b0, 1'b0, 16'h0000, 32'h0000_0000);
   endtask : tacc
   task automatic twr(input logic [1:0] s, input logic [4:0] i, input logic [15:0] d);
      if (slot(s, i) >= 0) tab[slot(s, i)] = d;
      tacc(1'b0, s, i, d);
   endtask : twr
   task automatic trd(input logic [1:0] s, input logic [4:0] i);
      tacc(1'b1, s, i, slot(s, i) >= 0 ? tab[slot(s, i)] : 16'h0000);
   endtask : trd
   task automatic look(input logic [1:0] p, input logic [4:0] q, input logic [1:0] m);
      int s;
      s = m == MODE_PORT_PRIO ? p * 8 + q[2:0] : m == MODE_PORT_ONLY ? p : m == MODE_PRIO_ONLY ? q : 99;
      @(posedge ref_clk);
      meter_port <= p;
      meter_prio <= q;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk({17'h0_0000, meter_rate}, {17'h0_0000, s < NUM_RATE ? tab[s] : 16'h0000});
   endtask : look
   function automatic logic [1:0] sel(input int k);
      return k < NUM_RATE ? SEL_RATE : k == NUM_RATE ? SEL_CBS : SEL_EBS;
   endfunction : sel
   initial begin
      void'($urandom(40));
      for (int k = 0; k < NUM_SLOT; k++) tab[k] = k < NUM_RATE ? RATE_RESET : BURST_RESET;
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      rd(REG_CONFIG, 33'h0_0000_0000);
      rd(REG_COMMAND, 33'h0_0000_0000);
      rd(REG_STATUS, 33'h0_0000_0000);
      rd(REG_WRITE_DATA, 33'h0_0000_0000);
      rd(REG_READ_DATA, 33'h0_0000_0000);
      rd(16'h1850, 33'h1_0000_0000);
      drv(1'b0, 1'b0, 16'h0000, 32'h0000_0000);
      @(negedge ref_clk);
      chk({1'b0, cbl, ebl}, {1'b0, BURST_RESET, BURST_RESET});
      chk({17'h0_0000, bkt}, {17'h0_0000, BUCKET_INIT});
      for (int k = 0; k < NUM_SLOT; k++) trd(sel(k), 5'(k));
      $display("reset values done");
      for (int k = 0; k < NUM_SLOT; k++) twr(sel(k), 5'(k), 16'($urandom));
      for (int k = NUM_SLOT - 1; k >= 0; k--) trd(sel(k), 5'(k));
      @(negedge ref_clk);
      chk({1'b0, cbl, ebl}, {1'b0, tab[SLOT_CBS], tab[SLOT_EBS]});
      twr(SEL_EBS, 5'h00, BURST_RESET);
      trd(SEL_EBS, 5'h00);
      $display("table write and read done");
      twr(SEL_RSVD, 5'h03, 16'h1234);
      twr(SEL_RATE, 5'h18, 16'h4321);
      trd(SEL_RSVD, 5'h03);
      trd(SEL_RATE, 5'h18);
      trd(SEL_RATE, 5'h03);
      rd(REG_COMMAND, 33'h0_0000_00A3);
      drv(1'b1, 1'b0, REG_READ_DATA, 32'hFFFF_FFFF);
      rd(REG_READ_DATA, {17'h0_0000, tab[3]});
      drv(1'b1, 1'b0, REG_WRITE_DATA, 32'hFFFF_5A5A);
      rd(REG_WRITE_DATA, 33'h0_0000_5A5A);
      drv(1'b0, 1'b0, 16'h0000, 32'h0000_0000);
      $display("reserved and holding registers done");
      for (int m = 0; m < 4; m++) begin
         drv(1'b1, 1'b0, REG_CONFIG, {29'h0000_0000, 2'(m), 1'b1});
         drv(1'b0, 1'b0, 16'h0000, 32'h0000_0000);
         @(negedge ref_clk);
         chk({30'h0, meter_mode, meter_enable}, {30'h0, 2'(m), 1'b1});
         look(2'($urandom), 5'h07, 2'(m));
         repeat (8) look(2'($urandom), 5'($urandom), 2'(m));
      end
      $display("lookup modes done");
      test_done();
   end
endmodule : imt_meter_table_test
`default_nettype wire
